/* bench/core_irq_model.sv */
`timescale 1ns/1ps
// ***
// core
// ***
module core_irq_model(
  input wire logic clk,
  input wire logic normalIrq,
  input wire logic fastIrq,
  output int takenCount
);
  // levels only: the core never acknowledges
  always @(posedge clk) if (normalIrq || fastIrq) takenCount <= takenCount + 1;
endmodule

/* bench/test_vectored_interrupt_collector.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t value mismatch", $time); end end
// ***
// bench
// ***
module test_vectored_interrupt_collector;
  import interrupt_collector_pkg::*;
  logic clk = 0, reset = 1, normalDisable = 0, fastDisable = 0, highestValid, normalIrq, fastIrq;
  source_vec_type requestLines = 0, sourceEnable = 0, fastSelect = 0, forceRequest = 0, np, fp;
  logic [7:0][31:0] priorityWords = 0;
  level_type priorityMask = 0, highestLevel;
  logic [31:0] normalPendingHigh, normalPendingLow, fastPendingHigh, fastPendingLow;
  source_index_type highestSource;
  int n_mismatch, samples_checked, takenCount, seed = 32'hCE69B157;
  logic [10:0] t;
  vectored_interrupt_collector vectored_interrupt_collector_inst(.*);
  core_irq_model core_irq_model_inst(.*);
  initial forever #12.5 clk = ~clk;
  function automatic source_vec_type r64();
    return {$random(seed), $random(seed)};
  endfunction
  function automatic logic [10:0] top(input source_vec_type p);
    level_type v;
    top = 0;
    for (int k = 0; k < 64; k++) begin
      v = priorityWords[k / 8][k % 8 * 4 +: 4];
      if (p[k] && v > priorityMask && v >= top[3:0]) top = {1'b1, 6'(k), v};
    end
  endfunction
  task automatic print_verdict();
    $display("%0d checked, %0d failed", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    for (int i = 0; i < 40; i++) begin
      {requestLines, sourceEnable, fastSelect} = i < 2 ? {{128{1'h1}}, 64'h0} : {r64(), r64(), r64()};
      forceRequest = r64() & r64();
      priorityWords = i < 2 ? {8{32'h7777_7777}} : {r64(), r64(), r64(), r64()};
      priorityMask = i == 1 ? 4'hF : i ? 4'(i) : 4'h6;
      {normalDisable, fastDisable} = {i % 5 == 2, i % 7 == 2};
      repeat (4) @(negedge clk);
      np = (requestLines | forceRequest) & sourceEnable;
      fp = np & fastSelect;
      np = np & ~fastSelect;
      t = top(np);
      `CHK({normalPendingHigh, normalPendingLow, fastPendingHigh, fastPendingLow}, {np, fp})
      `CHK({highestValid, highestSource, highestLevel}, t)
      `CHK({normalIrq, fastIrq}, {t[10] & !normalDisable, fp != 0 && !fastDisable})
      $display("test %0d done", i);
    end
    `CHK(takenCount > 0, 1'h1)
    print_verdict();
  end
  // tests need under 200 cycles
  initial begin
    #50000;
    n_mismatch++;
    print_verdict();
  end
endmodule

/* bench/vic_asserts.sv */
`timescale 1ns/1ps
// ***
// checks
// ***
module vic_asserts(
  input wire logic clk,
  input wire logic reset,
  input wire logic normalDisable,
  input wire logic fastDisable,
  input wire logic highestValid,
  input wire logic normalIrq,
  input wire logic fastIrq,
  input wire logic [63:0] sourceEnable,
  input wire logic [63:0] fastSelect,
  input wire logic [63:0] forceRequest,
  input wire logic [31:0] normalPendingHigh,
  input wire logic [31:0] normalPendingLow,
  input wire logic [31:0] fastPendingHigh,
  input wire logic [31:0] fastPendingLow,
  input wire logic [3:0] priorityMask,
  input wire logic [3:0] highestLevel,
  input wire logic [5:0] highestSource
);
  wire [63:0] n = {normalPendingHigh, normalPendingLow};
  wire [63:0] f = {fastPendingHigh, fastPendingLow};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_en; ((n | f) & ~$past(sourceEnable)) == 0; endproperty
  a_en: assert property (p_en) else $error("off source");
  property p_rt; (n & $past(fastSelect)) == 0 && (f & ~$past(fastSelect)) == 0; endproperty
  a_rt: assert property (p_rt) else $error("bad route");
  property p_fr; ($past(forceRequest & sourceEnable) & ~(n | f)) == 0; endproperty
  a_fr: assert property (p_fr) else $error("force lost");
  property p_ni; normalIrq == (highestValid && !$past(normalDisable)); endproperty
  a_ni: assert property (p_ni) else $error("bad normal");
  property p_fi; fastIrq == (f != 0 && !$past(fastDisable)); endproperty
  a_fi: assert property (p_fi) else $error("bad fast");
  property p_lv; highestValid |-> highestLevel > $past(priorityMask); endproperty
  a_lv: assert property (p_lv) else $error("masked");
  property p_hs; highestValid |-> n[highestSource]; endproperty
  a_hs: assert property (p_hs) else $error("idle top");
  property p_no; !highestValid |-> highestSource == 6'h00; endproperty
  a_no: assert property (p_no) else $error("stale top");
  c_tie: cover property (highestValid && highestSource == 6'h3F);
  c_both: cover property (normalIrq && fastIrq);
  c_drop: cover property (fastIrq ##1 !fastIrq);
endmodule
bind vectored_interrupt_collector vic_asserts vic_asserts_inst(.*);

/* hdl/interrupt_collector_defines.svh */
`ifndef INTERRUPT_COLLECTOR_DEFINES_SVH
`define INTERRUPT_COLLECTOR_DEFINES_SVH

// ****************************************
// sizes
// ****************************************
`define SOURCE_COUNT 64
`define SOURCE_INDEX_WIDTH 6
`define LEVEL_WIDTH 4
`define WORD_WIDTH 32
`define PRIORITY_WORDS 8
`define LEVELS_PER_WORD 8
`define CANDIDATE_WIDTH 11
`define CANDIDATE_VALID_BIT 10
`define CANDIDATE_SOURCE_LSB 4
`define TREE_PASSES 6

// ****************************************
// reset values
// ****************************************
`define PENDING_RESET 64'h0000_0000_0000_0000
`define SOURCE_RESET 6'h00
`define LEVEL_RESET 4'h0
`define CANDIDATE_RESET 11'h000

`endif

/* hdl/interrupt_collector_pkg.sv */
`include "interrupt_collector_defines.svh"

package interrupt_collector_pkg;

  typedef logic [`SOURCE_COUNT-1:0] source_vec_type;
  typedef logic [`LEVEL_WIDTH-1:0] level_type;
  typedef logic [`SOURCE_INDEX_WIDTH-1:0] source_index_type;

  typedef struct packed {
    source_vec_type syncFirst;
    source_vec_type syncSecond;
    source_vec_type normalPending;
    source_vec_type fastPending;
    logic highestValid;
    source_index_type highestSource;
    level_type highestLevel;
    logic normalIrq;
    logic fastIrq;
  } state_type;

endpackage

/* hdl/vectored_interrupt_collector.sv */
`timescale 1ns/1ps
`include "interrupt_collector_defines.svh"

module vectored_interrupt_collector
  import interrupt_collector_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`SOURCE_COUNT-1:0] requestLines,
  input wire logic [`SOURCE_COUNT-1:0] sourceEnable,
  input wire logic [`SOURCE_COUNT-1:0] fastSelect,
  input wire logic [`SOURCE_COUNT-1:0] forceRequest,
  input wire logic [`PRIORITY_WORDS-1:0][`WORD_WIDTH-1:0] priorityWords,
  input wire logic [`LEVEL_WIDTH-1:0] priorityMask,
  input wire logic normalDisable,
  input wire logic fastDisable,
  output logic [`WORD_WIDTH-1:0] normalPendingHigh,
  output logic [`WORD_WIDTH-1:0] normalPendingLow,
  output logic [`WORD_WIDTH-1:0] fastPendingHigh,
  output logic [`WORD_WIDTH-1:0] fastPendingLow,
  output logic highestValid,
  output logic [`SOURCE_INDEX_WIDTH-1:0] highestSource,
  output logic [`LEVEL_WIDTH-1:0] highestLevel,
  output logic normalIrq,
  output logic fastIrq
);

  // ****************************************
  // helpers
  // ****************************************
  // level of one source: eight nibbles to each priority word
  function automatic level_type levelOf(
    input logic [`PRIORITY_WORDS-1:0][`WORD_WIDTH-1:0] words,
    input int idx
  );
    logic [`WORD_WIDTH-1:0] w;
    w = words[idx / `LEVELS_PER_WORD];
    levelOf = w[(idx % `LEVELS_PER_WORD) * `LEVEL_WIDTH +: `LEVEL_WIDTH];
  endfunction

  function automatic logic [`WORD_WIDTH-1:0] upperHalf(
    input source_vec_type vec
  );
    upperHalf = vec[`SOURCE_COUNT-1:`WORD_WIDTH];
  endfunction

  function automatic logic [`WORD_WIDTH-1:0] lowerHalf(
    input source_vec_type vec
  );
    lowerHalf = vec[`WORD_WIDTH-1:0];
  endfunction

  // a requesting source lands in exactly one of the two pending sets; any other source lands in neither
  function automatic source_vec_type routeOf(
    input source_vec_type requesting,
    input source_vec_type select,
    input logic wantFast
  );
    if (wantFast) begin
      routeOf = requesting & select;
    end else begin
      routeOf = requesting & ~select;
    end
  endfunction

  // the global block overrides every per-source enable
  function automatic logic raiseOf(
    input source_vec_type vec,
    input logic blocked
  );
    raiseOf = (|vec) && !blocked;
  endfunction

  // level 0 never beats any mask; software keeps that level for parked sources
  function automatic source_vec_type eligibleOf(
    input source_vec_type pending,
    input logic [`PRIORITY_WORDS-1:0][`WORD_WIDTH-1:0] words,
    input level_type mask
  );
    source_vec_type result;
    result = '0;
    for (int k = 0; k < `SOURCE_COUNT; k++) begin
      result[k] = pending[k] && (levelOf(words, k) > mask);
    end
    eligibleOf = result;
  endfunction

  // candidate word: valid flag, source number, level
  function automatic logic [`CANDIDATE_WIDTH-1:0] candidateOf(
    input logic valid,
    input int idx,
    input level_type lvl
  );
    logic [`SOURCE_INDEX_WIDTH-1:0] src;
    src = idx[`SOURCE_INDEX_WIDTH-1:0];
    if (valid) begin
      candidateOf = {1'h1, src, lvl};
    end else begin
      candidateOf = `CANDIDATE_RESET;
    end
  endfunction

  function automatic level_type levelField(
    input logic [`CANDIDATE_WIDTH-1:0] cand
  );
    levelField = cand[`LEVEL_WIDTH-1:0];
  endfunction

  function automatic source_index_type sourceField(
    input logic [`CANDIDATE_WIDTH-1:0] cand
  );
    sourceField = cand[`CANDIDATE_SOURCE_LSB +: `SOURCE_INDEX_WIDTH];
  endfunction

  // upper always holds the higher source numbers, so it takes a tie
  function automatic logic [`CANDIDATE_WIDTH-1:0] mergeOf(
    input logic [`CANDIDATE_WIDTH-1:0] lower,
    input logic [`CANDIDATE_WIDTH-1:0] upper
  );
    logic upperWins;
    upperWins = upper[`CANDIDATE_VALID_BIT]
      && (!lower[`CANDIDATE_VALID_BIT] || (levelField(upper) >= levelField(lower)));
    if (upperWins) begin
      mergeOf = upper;
    end else begin
      mergeOf = lower;
    end
  endfunction

  // six-level tree instead of a 64-deep compare chain, to keep the path short
  function automatic logic [`CANDIDATE_WIDTH-1:0] highestOf(
    input source_vec_type eligible,
    input logic [`PRIORITY_WORDS-1:0][`WORD_WIDTH-1:0] words
  );
    logic [`CANDIDATE_WIDTH-1:0] node [`SOURCE_COUNT];
    for (int k = 0; k < `SOURCE_COUNT; k++) begin
      node[k] = candidateOf(eligible[k], k, levelOf(words, k));
    end
    // each pass halves the field; node k is written only after 2k and 2k+1 are read
    for (int stage = 0; stage < `TREE_PASSES; stage++) begin
      for (int k = 0; k < `SOURCE_COUNT / 2; k++) begin
        if (k < (`SOURCE_COUNT >> (stage + 1))) begin
          node[k] = mergeOf(node[2 * k], node[2 * k + 1]);
        end
      end
    end
    highestOf = node[0];
  endfunction

  // ****************************************
  // state
  // ****************************************
  state_type state_r;
  state_type state_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    source_vec_type requesting;
    source_vec_type normalEligible;
    logic [`CANDIDATE_WIDTH-1:0] winner;
    requesting = '0;
    normalEligible = '0;
    winner = `CANDIDATE_RESET;
    state_nxt = state_r;
    // pins are asynchronous, so two flops before use
    state_nxt.syncFirst = requestLines;
    state_nxt.syncSecond = state_r.syncFirst;
    // forced bits join the synchronised lines, gated by the enables
    requesting = (state_r.syncSecond | forceRequest) & sourceEnable;
    state_nxt.normalPending = routeOf(requesting, fastSelect, 1'h0);
    state_nxt.fastPending = routeOf(requesting, fastSelect, 1'h1);
    normalEligible = eligibleOf(state_nxt.normalPending, priorityWords, priorityMask);
    winner = highestOf(normalEligible, priorityWords);
    state_nxt.highestValid = winner[`CANDIDATE_VALID_BIT];
    state_nxt.highestSource = sourceField(winner);
    state_nxt.highestLevel = levelField(winner);
    state_nxt.normalIrq = raiseOf(normalEligible, normalDisable);
    state_nxt.fastIrq = raiseOf(state_nxt.fastPending, fastDisable);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r.syncFirst <= `PENDING_RESET;
      state_r.syncSecond <= `PENDING_RESET;
      state_r.normalPending <= `PENDING_RESET;
      state_r.fastPending <= `PENDING_RESET;
      state_r.highestValid <= 1'h0;
      state_r.highestSource <= `SOURCE_RESET;
      state_r.highestLevel <= `LEVEL_RESET;
      state_r.normalIrq <= 1'h0;
      state_r.fastIrq <= 1'h0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign normalPendingHigh = upperHalf(state_r.normalPending);
  assign normalPendingLow = lowerHalf(state_r.normalPending);
  assign fastPendingHigh = upperHalf(state_r.fastPending);
  assign fastPendingLow = lowerHalf(state_r.fastPending);
  assign highestValid = state_r.highestValid;
  assign highestSource = state_r.highestSource;
  assign highestLevel = state_r.highestLevel;
  assign normalIrq = state_r.normalIrq;
  assign fastIrq = state_r.fastIrq;

endmodule
